// ### common/cis_pkg.sv
package cis_pkg;

  // register page and addresses on the special-function-register bus
  localparam logic [3:0] CIS_PAGE      = 4'h0;
  localparam logic [7:0] CIS_ADDR_CMP1 = 8'h9E;
  localparam logic [7:0] CIS_ADDR_CMP0 = 8'h9F;
  localparam logic [7:0] CIS_RESET_VAL = 8'hFF;

  // field positions inside a select register
  localparam int CIS_NEG_MSB = 7;
  localparam int CIS_NEG_LSB = 4;
  localparam int CIS_POS_MSB = 3;
  localparam int CIS_POS_LSB = 0;

  // one-hot select widths
  localparam int CIS_NEG_W = 13;
  localparam int CIS_POS_W = 13;

  // negative mux select bit positions
  localparam int NEG_P0_1 = 0;
  localparam int NEG_P0_3 = 1;
  localparam int NEG_P0_5 = 2;
  localparam int NEG_P0_7 = 3;
  localparam int NEG_P1_5 = 4;
  localparam int NEG_P1_7 = 5;
  localparam int NEG_P2_1 = 6;
  localparam int NEG_P2_3 = 7;
  localparam int NEG_P2_5 = 8;
  localparam int NEG_TOUCH = 9;
  localparam int NEG_HALF  = 10;
  localparam int NEG_DIG   = 11;
  localparam int NEG_GND   = 12;

  // positive mux select bit positions
  localparam int POS_P0_0 = 0;
  localparam int POS_P0_2 = 1;
  localparam int POS_P0_4 = 2;
  localparam int POS_P0_6 = 3;
  localparam int POS_P1_6 = 4;
  localparam int POS_P2_0 = 5;
  localparam int POS_P2_2 = 6;
  localparam int POS_P2_4 = 7;
  localparam int POS_P2_6 = 8;
  localparam int POS_TOUCH = 9;
  localparam int POS_HALF  = 10;
  localparam int POS_VBAT  = 11;
  localparam int POS_VDD   = 12;

  // input codes
  localparam logic [3:0] C_0000 = 4'h0;
  localparam logic [3:0] C_0001 = 4'h1;
  localparam logic [3:0] C_0010 = 4'h2;
  localparam logic [3:0] C_0011 = 4'h3;
  localparam logic [3:0] C_0110 = 4'h6;
  localparam logic [3:0] C_0111 = 4'h7;
  localparam logic [3:0] C_1000 = 4'h8;
  localparam logic [3:0] C_1001 = 4'h9;
  localparam logic [3:0] C_1010 = 4'hA;
  localparam logic [3:0] C_1011 = 4'hB;
  localparam logic [3:0] C_1100 = 4'hC;
  localparam logic [3:0] C_1101 = 4'hD;
  localparam logic [3:0] C_1110 = 4'hE;
  localparam logic [3:0] C_1111 = 4'hF;

  // bus request toward the block
  typedef struct packed {
    logic       wr;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cis_req_s;

  // one comparator's decoded selects
  typedef struct packed {
    logic [CIS_NEG_W-1:0] neg;
    logic [CIS_POS_W-1:0] pos;
  } cis_sel_s;

endpackage

// ### hw/cis_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Comparator 0 negative code 0-3 picks P0.1/3/5/7, 6-7 P1.5/7, 8-A P2.1/3/5.
// - Comparator 0 negative C touch, D half supply, E digital supply, F ground, 4/5/B reserved.
// - Comparator 0 positive code 0-3 picks P0.0/2/4/6, 7 P1.6, 8-B P2.0/2/4/6.
// - Comparator 0 positive C touch, D half supply, E battery, F MCU supply, 4-6 reserved.
// - Comparator 1 negative field decodes exactly like comparator 0 negative.
// - Comparator 1 positive field decodes exactly like comparator 0 positive.
// - Comparator 0 select register sits at page 0, address 9F, all bits RW, resets to FF.
// - Comparator 1 select register sits at page 0, address 9E, all bits RW, resets to FF.
// - The half-supply divider is on only while some field selects the half-supply code.
module cis_top
  import cis_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire cis_req_s             sfr_req,
  output logic [7:0]                sfr_rdata,
  output cis_sel_s                  cmp0_sel,
  output cis_sel_s                  cmp1_sel,
  output logic                      half_div_en
);

  ////////////////////////////////////////////////////////////////////////////
  // decoders shared by both comparators

  function automatic logic [CIS_NEG_W-1:0] dec_neg(input logic [3:0] code);
    logic [CIS_NEG_W-1:0] s;
    s = '0;
    unique case (code)
      C_0000:  s[NEG_P0_1]  = 1'b1;
      C_0001:  s[NEG_P0_3]  = 1'b1;
      C_0010:  s[NEG_P0_5]  = 1'b1;
      C_0011:  s[NEG_P0_7]  = 1'b1;
      C_0110:  s[NEG_P1_5]  = 1'b1;
      C_0111:  s[NEG_P1_7]  = 1'b1;
      C_1000:  s[NEG_P2_1]  = 1'b1;
      C_1001:  s[NEG_P2_3]  = 1'b1;
      C_1010:  s[NEG_P2_5]  = 1'b1;
      C_1100:  s[NEG_TOUCH] = 1'b1;
      C_1101:  s[NEG_HALF]  = 1'b1;
      C_1110:  s[NEG_DIG]   = 1'b1;
      C_1111:  s[NEG_GND]   = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  function automatic logic [CIS_POS_W-1:0] dec_pos(input logic [3:0] code);
    logic [CIS_POS_W-1:0] s;
    s = '0;
    unique case (code)
      C_0000:  s[POS_P0_0]  = 1'b1;
      C_0001:  s[POS_P0_2]  = 1'b1;
      C_0010:  s[POS_P0_4]  = 1'b1;
      C_0011:  s[POS_P0_6]  = 1'b1;
      C_0111:  s[POS_P1_6]  = 1'b1;
      C_1000:  s[POS_P2_0]  = 1'b1;
      C_1001:  s[POS_P2_2]  = 1'b1;
      C_1010:  s[POS_P2_4]  = 1'b1;
      C_1011:  s[POS_P2_6]  = 1'b1;
      C_1100:  s[POS_TOUCH] = 1'b1;
      C_1101:  s[POS_HALF]  = 1'b1;
      C_1110:  s[POS_VBAT]  = 1'b1;
      C_1111:  s[POS_VDD]   = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  function automatic cis_sel_s dec_reg(input logic [7:0] r);
    cis_sel_s s;
    s.neg = dec_neg(r[CIS_NEG_MSB:CIS_NEG_LSB]);
    s.pos = dec_pos(r[CIS_POS_MSB:CIS_POS_LSB]);
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator indexing and address match

  // two comparators share every piece of logic below
  localparam int                   NUM_CMP   = 2;
  localparam int                   CMP0_IDX  = 0;
  localparam int                   CMP1_IDX  = 1;
  // reset code FF: ground on minus, MCU supply on plus
  localparam logic [CIS_NEG_W-1:0] NEG_RESET = CIS_NEG_W'(1) << NEG_GND;
  localparam logic [CIS_POS_W-1:0] POS_RESET = CIS_POS_W'(1) << POS_VDD;
  localparam cis_sel_s             SEL_RESET = '{neg: NEG_RESET, pos: POS_RESET};

  // register address that belongs to a comparator index
  function automatic logic [7:0] cmp_addr(input int idx);
    logic [7:0] a;
    a = CIS_ADDR_CMP0;
    if (idx == CMP1_IDX) begin
      a = CIS_ADDR_CMP1;
    end
    return a;
  endfunction

  // page and address must both match; another page never answers
  // one address decode serves both the write and the read path
  function automatic logic reg_hit(input cis_req_s req, input int idx);
    return (req.page == CIS_PAGE) && (req.addr == cmp_addr(idx));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // select registers, one byte per comparator, addressed by index

  logic [7:0] input_select_ff  [NUM_CMP];
  logic [7:0] nxt_input_select [NUM_CMP];

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_reg
    always_comb begin
      nxt_input_select[g] = input_select_ff[g];
      // write on page and address match
      // reserved codes are stored as written
      if (sfr_req.wr && reg_hit(sfr_req, g)) begin
        nxt_input_select[g] = sfr_req.wdata;
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        input_select_ff[g] <= CIS_RESET_VAL;
      end else begin
        input_select_ff[g] <= nxt_input_select[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mux selects; decoding the next value keeps the outputs on flops

  cis_sel_s sel_ff  [NUM_CMP];
  cis_sel_s nxt_sel [NUM_CMP];

  for (genvar g = 0; g < NUM_CMP; g++) begin : g_sel
    always_comb begin
      // a reserved code leaves that field's selects clear
      nxt_sel[g] = dec_reg(nxt_input_select[g]);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sel_ff[g] <= SEL_RESET;
      end else begin
        sel_ff[g] <= nxt_sel[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: the byte of the register addressed, zero elsewhere

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    // no read strobe: the address alone picks the byte
    nxt_rdata = '0;
    for (int i = 0; i < NUM_CMP; i++) begin
      // read back the stored value
      // a same-cycle write shows its new value at once
      if (reg_hit(sfr_req, i)) begin
        nxt_rdata = nxt_input_select[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-supply divider enable

  logic half_div_en_ff;
  logic nxt_half_div_en;

  always_comb begin
    nxt_half_div_en = 1'b0;
    for (int i = 0; i < NUM_CMP; i++) begin
      // divider draws current only when chosen
      nxt_half_div_en = nxt_half_div_en | nxt_sel[i].neg[NEG_HALF] | nxt_sel[i].pos[POS_HALF];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // the reset codes pick no half supply, so the enable starts low
      half_div_en_ff <= 1'b0;
    end else begin
      half_div_en_ff <= nxt_half_div_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the flops

  assign sfr_rdata   = rdata_ff;
  assign cmp0_sel    = sel_ff[CMP0_IDX];
  assign cmp1_sel    = sel_ff[CMP1_IDX];
  assign half_div_en = half_div_en_ff;

endmodule

// ### tb/cis_checker_properties.sv
`timescale 1ns/100ps
module cis_checker
  import cis_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire cis_req_s   sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire cis_sel_s   cmp0_sel,
  input wire cis_sel_s   cmp1_sel,
  input wire logic       half_div_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic       w0;
  logic       w1;
  logic [3:0] neg_code;
  logic [3:0] pos_code;
  assign w0       = sfr_req.wr && sfr_req.page == CIS_PAGE && sfr_req.addr == CIS_ADDR_CMP0;
  assign w1       = sfr_req.wr && sfr_req.page == CIS_PAGE && sfr_req.addr == CIS_ADDR_CMP1;
  assign neg_code = sfr_req.wdata[CIS_NEG_MSB:CIS_NEG_LSB];
  assign pos_code = sfr_req.wdata[CIS_POS_MSB:CIS_POS_LSB];
  ////////////////////////////////////////////////////////////////////////////////
  AST_GND: assert property (w0 && neg_code == C_1111 |=> cmp0_sel.neg == 13'h1000)
    else $error("ground select missing");
  AST_C1NEG: assert property (w1 && neg_code == C_0000 |=> cmp1_sel.neg == 13'h0001)
    else $error("comparator 1 negative decode wrong");
  AST_ONEHOT: assert property ($onehot0(cmp0_sel.neg) && $onehot0(cmp0_sel.pos)
    && $onehot0(cmp1_sel.neg) && $onehot0(cmp1_sel.pos)) else $error("select not one-hot");
  AST_RSV: assert property (w0 && pos_code inside {[4'h4:4'h6]} |=> cmp0_sel.pos == '0)
    else $error("reserved code drives a select");
  AST_HALF: assert property (half_div_en == (cmp0_sel.neg[NEG_HALF] |
    cmp0_sel.pos[POS_HALF] | cmp1_sel.neg[NEG_HALF] | cmp1_sel.pos[POS_HALF]))
    else $error("divider enable wrong");
  AST_RD0: assert property (w0 |=> sfr_rdata == $past(sfr_req.wdata))
    else $error("comparator 0 readback wrong");
  AST_RD1: assert property (w1 |=> sfr_rdata == $past(sfr_req.wdata))
    else $error("comparator 1 readback wrong");
  AST_BADPG: assert property (sfr_req.page != CIS_PAGE |=> sfr_rdata == 8'h00)
    else $error("other page answered");
  AST_STABLE: assert property (!sfr_req.wr |=> $stable(cmp0_sel) && $stable(cmp1_sel))
    else $error("select moved without a write");
  cover property (w0 && neg_code == C_1101);
  cover property (w1 ##1 w0);
  cover property (sfr_req.wr && sfr_req.page != CIS_PAGE);
  cover property (w1 && pos_code == C_1100);
endmodule
bind cis_top cis_checker chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .cmp0_sel(cmp0_sel), .cmp1_sel(cmp1_sel), .half_div_en(half_div_en));

// ### tb/cis_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("unexpected %0t got %h want %h", $time, a, b); \
    end \
  end
module tb;
  import cis_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       half_div_en;
  logic [7:0] sfr_rdata;
  cis_req_s   sfr_req = '0;
  cis_sel_s   cmp0_sel;
  cis_sel_s   cmp1_sel;
  int         num_errors = 0;
  int         cmp_count = 0;
  // bit index per code, -1 for reserved
  int         neg_map[16] = '{0, 1, 2, 3, -1, -1, 4, 5, 6, 7, 8, -1, 9, 10, 11, 12};
  int         pos_map[16] = '{0, 1, 2, 3, -1, -1, -1, 4, 5, 6, 7, 8, 9, 10, 11, 12};
  always #20 sys_clk = ~sys_clk;
  cis_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .cmp0_sel(cmp0_sel), .cmp1_sel(cmp1_sel), .half_div_en(half_div_en));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [12:0] hot(int i);
    return (i < 0) ? 13'h0000 : 13'h0001 << i;
  endfunction
  task automatic acc(logic wr, logic [3:0] pg, logic [7:0] ad, logic [7:0] d);
    @(posedge sys_clk);
    sfr_req <= '{wr, pg, ad, d};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK({cmp0_sel, cmp1_sel, half_div_en, sfr_rdata}, {{4{13'h1000}}, 1'b0, 8'h00})
    acc(1'b0, CIS_PAGE, CIS_ADDR_CMP0, 8'h00);
    `CHK(sfr_rdata, CIS_RESET_VAL)
    acc(1'b0, CIS_PAGE, CIS_ADDR_CMP1, 8'h00);
    `CHK(sfr_rdata, CIS_RESET_VAL)
    $display("reset done");
  endtask
  // every code in both fields; the two nibbles differ so a swap shows
  task automatic t_codes(logic [7:0] ad);
    cis_sel_s   s;
    logic [3:0] n;
    for (int c = 0; c < 16; c++) begin
      n = c[3:0];
      acc(1'b1, CIS_PAGE, ad, {n, ~n});
      s = (ad == CIS_ADDR_CMP0) ? cmp0_sel : cmp1_sel;
      `CHK(sfr_rdata, {n, ~n})
      `CHK(s.neg, hot(neg_map[n]))
      `CHK(s.pos, hot(pos_map[~n]))
      `CHK(half_div_en, (n == C_1101 || n == C_0010))
    end
    $display("codes done %h", ad);
  endtask
  task automatic t_refused();
    cis_sel_s s;
    cis_sel_s s1;
    s  = cmp0_sel;
    s1 = cmp1_sel;
    acc(1'b1, 4'h1, CIS_ADDR_CMP0, 8'h00);
    `CHK({sfr_rdata, cmp0_sel}, {8'h00, s})
    acc(1'b1, 4'h1, CIS_ADDR_CMP1, 8'h00);
    `CHK({sfr_rdata, cmp1_sel}, {8'h00, s1})
    acc(1'b1, CIS_PAGE, 8'h9D, 8'h00);
    `CHK({sfr_rdata, cmp0_sel, cmp1_sel}, {8'h00, s, s1})
    $display("refused done");
  endtask
  task automatic t_b2b();
    @(posedge sys_clk);
    sfr_req <= '{1'b1, CIS_PAGE, CIS_ADDR_CMP0, 8'hD7};
    @(posedge sys_clk);
    sfr_req <= '{1'b1, CIS_PAGE, CIS_ADDR_CMP1, 8'h3C};
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
    @(negedge sys_clk);
    `CHK({cmp0_sel, half_div_en, sfr_rdata}, {13'h0400, 13'h0010, 1'b1, 8'h3C})
    `CHK(cmp1_sel, {13'h0008, 13'h0200})
    acc(1'b0, CIS_PAGE, CIS_ADDR_CMP0, 8'h00);
    `CHK(sfr_rdata, 8'hD7)
    $display("back to back done");
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_codes(CIS_ADDR_CMP0);
    t_codes(CIS_ADDR_CMP1);
    t_refused();
    t_b2b();
    conclude();
  end
endmodule
